// [verilog/address_controller_pkg.sv]
// Purpose: constants shared by the shared RAM address controller
// Assumes: clk is the oscillator output, 25 MHz (40 ns)
// Notes:   control register bit positions, decode values, timing counts
package address_controller_pkg;

	// clock and timing
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          HS_LONG_NS     = 8000;
	localparam int          HS_LONG_CYC    = (HS_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  HS_LONG_CNT    = 8'(HS_LONG_CYC);
	localparam logic [3:0]  EXT_RESET_CNT  = 4'h8;
	localparam logic [5:0]  VSTOP_MAX_CNT  = 6'h20;
	localparam logic [3:0]  REFRESH_BURST  = 4'h8;

	// video timing window on the reference counter
	localparam logic [3:0]  WIN_TA         = 4'h6;
	localparam logic [3:0]  WIN_TB         = 4'h8;
	localparam logic [3:0]  WIN_TC         = 4'ha;

	// control register bit positions
	localparam int          CB_V0          = 0;
	localparam int          CB_V2          = 2;
	localparam int          CB_F0          = 3;
	localparam int          CB_F6          = 9;
	localparam int          CB_PAGE        = 10;
	localparam int          CB_R0          = 11;
	localparam int          CB_R1          = 12;
	localparam int          CB_M0          = 13;
	localparam int          CB_M1          = 14;
	localparam int          CB_TY          = 15;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;

	// address decode
	localparam logic [10:0] CTRL_RANGE     = 11'h7fe;
	localparam logic [7:0]  IO_PAGE        = 8'hff;
	localparam logic [2:0]  VIDEO_MODE_ALL = 3'h7;

	// block select values
	localparam logic [2:0]  BS_RAM         = 3'h0;
	localparam logic [2:0]  BS_ROM0        = 3'h1;
	localparam logic [2:0]  BS_ROM1        = 3'h2;
	localparam logic [2:0]  BS_CART        = 3'h3;
	localparam logic [2:0]  BS_IO0         = 3'h4;
	localparam logic [2:0]  BS_IO1         = 3'h5;
	localparam logic [2:0]  BS_IO2         = 3'h6;
	localparam logic [2:0]  BS_CTRL        = 3'h7;

	// video clock alignment state
	typedef enum logic {VS_RUN = 1'b0, VS_WAIT = 1'b1} vsync_e;

	// division factor ahead of display counter bit 4
	function automatic logic [3:0] div_x(input logic [2:0] mode);
		case (mode)
			3'h1:    div_x = 4'h3;
			3'h3:    div_x = 4'h2;
			default: div_x = 4'h1;
		endcase
	endfunction

	// division factor ahead of display counter bit 5
	function automatic logic [3:0] div_y(input logic [2:0] mode);
		case (mode)
			3'h0:    div_y = 4'hc;
			3'h2:    div_y = 4'h3;
			3'h4:    div_y = 4'h2;
			default: div_y = 4'h1;
		endcase
	endfunction

endpackage

// [verilog/shared_ram_address_controller.sv]
// Purpose: timing and address core of a shared dynamic RAM controller
// Assumes: clk is the oscillator output; pins pass three-flop synchronisers
// Notes:   processor half of each cycle follows the video/refresh half
//
// Functional notes
// - three-bit block select names address range
// - block select is a pure decode
// - map type picks ROM map or RAM map
// - register strobe: range, write, enable clock
// - any reset clears all sixteen bits
// - odd address write sets one bit
// - even address write clears; data ignored
// - A4-A1 pick bit, A0 picks value
// - video mode sets division and cleared bits
// - bank strobe chosen from address
// - long sync low extends refresh burst
// - video clock pin low resets register
// - strobes and clocks run during partial reset
// - video clock stop bounded, then resumes
// - data address edge checked against window
// - restart at window centre after error
// - two rate bits give three modes
// - address dependent mode picks slow ranges
// - fast mode denies video RAM access
// - preload loads offset, clears low bits
// - sync fall starts eight refresh addresses
// - map 0 substitutes page bit for A15
module shared_ram_address_controller
	import address_controller_pkg::*;
(
	// clock and complete reset
	input  wire logic        clk,
	input  wire logic        reset,
	// processor side
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_rw,
	output logic      [2:0]  block_select,
	output logic             e_clk,
	output logic             q_clk,
	// video generator side
	input  wire logic        display_addr_lsb,
	input  wire logic        horiz_sync_in,
	input  wire logic        video_clock_pin_i,
	output logic             video_clock_pin_o,
	output logic             video_clock_pin_oe,
	// dynamic RAM side
	output logic      [6:0]  ram_addr,
	output logic             ram_addr_bit7,
	output logic             row_strobe_bank0_n,
	output logic             col_strobe_n,
	output logic             write_enable_n
);

	localparam logic [2:0] SYNC_INIT = 3'b101;

	logic [2:0]  s1_q, s2_q, s3_q, pin_q;
	logic [15:0] ctrl_q;
	logic [3:0]  low_cnt_q, phase_q, vref_q, ref_left_q, xcnt_q, ycnt_q;
	logic        cycle_div8_q, e_q, q_q, row_strobe_bank0_n_q, pin7_q, cas_n_q, we_n_q;
	logic [7:0]  ram_addr_q, hs_low_q;
	logic [6:0]  refresh_q;
	logic [15:1] disp_q;
	logic [1:0]  vdiv_q;
	logic        video_clock_pin_q;
	logic [5:0]  stop_cnt_q;
	vsync_e      vsync_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// pin synchronisers: a change counts once the second and third flops agree
	wire [2:0] pin_in = {video_clock_pin_i, display_addr_lsb, horiz_sync_in};
	wire [2:0] agree  = ~(s2_q ^ s3_q);
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					s1_q[gi]  <= SYNC_INIT[gi];
					s2_q[gi]  <= SYNC_INIT[gi];
					s3_q[gi]  <= SYNC_INIT[gi];
					pin_q[gi] <= SYNC_INIT[gi];
				end
				else
				begin
					s1_q[gi]  <= pin_in[gi];
					s2_q[gi]  <= s1_q[gi];
					s3_q[gi]  <= s2_q[gi];
					pin_q[gi] <= agree[gi] ? s3_q[gi] : pin_q[gi];
				end
			end
		end
	endgenerate

	// qualified edges of the synchronised pins
	wire vpin_s  = pin_q[2];
	wire da_s    = pin_q[1];
	wire hs_s    = pin_q[0];
	wire da_rise = agree[1] & s3_q[1] & ~da_s;
	wire da_fall = agree[1] & ~s3_q[1] & da_s;
	wire hs_rise = agree[0] & s3_q[0] & ~hs_s;
	wire hs_fall = agree[0] & ~s3_q[0] & hs_s;

	// control register fields
	wire [2:0] video_mode     = ctrl_q[CB_V2:CB_V0];
	wire [6:0] display_offset = ctrl_q[CB_F6:CB_F0];
	wire       page_bit       = ctrl_q[CB_PAGE];
	wire       rate_high      = ctrl_q[CB_R1];
	wire       rate_low       = ctrl_q[CB_R0];
	wire       mem_size_low   = ctrl_q[CB_M0];
	wire       mem_size_high  = ctrl_q[CB_M1];
	wire       map_type_bit   = ctrl_q[CB_TY];

	wire       io_page  = cpu_addr[15:8] == IO_PAGE;
	wire [2:0] io_sel   = (cpu_addr[7:5] == 3'h0) ? BS_IO0 :
	                      (cpu_addr[7:5] == 3'h1) ? BS_IO1 :
	                      (cpu_addr[7:5] == 3'h2) ? BS_IO2 :
	                      (cpu_addr[7:5] == 3'h7) ? BS_ROM1 : BS_CTRL;
	wire [2:0] map0_sel = ~cpu_addr[15] ? BS_RAM :
	                      (cpu_addr[14:13] == 2'h0) ? BS_ROM0 :
	                      (cpu_addr[14:13] == 2'h1) ? BS_ROM1 : BS_CART;
	// pure decode of address and map type
	assign block_select = io_page ? io_sel : (map_type_bit ? BS_RAM : map0_sel);

	// control write strobe: register range, write, enable clock high
	wire       ctrl_sel = cpu_addr[15:5] == CTRL_RANGE;
	wire       ctrl_wr  = ctrl_sel & ~cpu_rw & e_q;
	wire [3:0] ctrl_idx = cpu_addr[4:1];

	// partial reset once the video clock pin sits low eight cycles
	wire part_reset = low_cnt_q == EXT_RESET_CNT;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			low_cnt_q <= 4'h0;
		else if (vpin_s)
			low_cnt_q <= 4'h0;
		else if (!part_reset)
			low_cnt_q <= low_cnt_q + 4'h1;
	end

	// one bit per write, A0 is the value, data ignored
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ctrl_q <= CTRL_RESET;
		else if (part_reset)
			ctrl_q <= CTRL_RESET;
		else if (ctrl_wr)
			ctrl_q[ctrl_idx] <= cpu_addr[0];
	end

	wire slow_region = ~cpu_addr[15] | (io_page & (cpu_addr[7:5] == 3'h0));
	wire div16_now   = ~rate_high & (~rate_low | slow_region);
	wire cycle_last  = cycle_div8_q ? (phase_q[2:0] == 3'h7) : (phase_q == 4'hf);

	// machine cycle phases; first half video/refresh, second half processor
	wire in_cpu_half = cycle_div8_q ? phase_q[2] : phase_q[3];
	wire [2:0] sub   = cycle_div8_q ? {1'b0, phase_q[1:0]} : phase_q[2:0];
	wire cas_zone    = cycle_div8_q ? phase_q[1] : phase_q[2];
	wire half_last   = cycle_div8_q ? (phase_q[1:0] == 2'h3) : (phase_q[2:0] == 3'h7);
	wire q_next      = cycle_div8_q ? (phase_q[2] ^ phase_q[1]) : (phase_q[3] ^ phase_q[2]);

	// sequencer free-runs through a partial reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			phase_q      <= 4'h0;
			cycle_div8_q <= 1'b0;
		end
		else if (cycle_last)
		begin
			phase_q      <= 4'h0;
			cycle_div8_q <= ~div16_now;
		end
		else
			phase_q <= phase_q + 4'h1;
	end

	// refresh burst; a long sync low keeps it going
	wire long_low    = ~hs_s & (hs_low_q == HS_LONG_CNT);
	wire refresh_act = (ref_left_q != 4'h0) | long_low;
	wire ref_step    = ~in_cpu_half & refresh_act & half_last;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			hs_low_q   <= 8'h0;
			ref_left_q <= 4'h0;
			refresh_q  <= 7'h0;
		end
		else
		begin
			hs_low_q <= hs_s ? 8'h0 : (long_low ? hs_low_q : hs_low_q + 8'h1);
			if (hs_fall)
				ref_left_q <= REFRESH_BURST;
			else if (ref_step && ref_left_q != 4'h0)
				ref_left_q <= ref_left_q - 4'h1;
			if (ref_step)
				refresh_q <= refresh_q + 7'h1;
		end
	end

	// display counter division from the video mode
	wire [3:0] x_val   = div_x(video_mode);
	wire [3:0] y_val   = div_y(video_mode);
	wire lo_carry      = disp_q[3:1] == 3'h7;
	wire x_wrap        = xcnt_q == (x_val - 4'h1);
	wire b4_tick       = da_fall & lo_carry & x_wrap;
	wire y_tick        = b4_tick & disp_q[4];
	wire y_wrap        = ycnt_q == (y_val - 4'h1);
	wire vp_pulse      = hs_rise & da_s;
	wire hr_clear      = ~hs_s & (video_mode != VIDEO_MODE_ALL);

	// display address counter, preload and horizontal clear
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			disp_q <= 15'h0;
			xcnt_q <= 4'h0;
			ycnt_q <= 4'h0;
		end
		// vertical preload from the offset bits
		else if (vp_pulse)
		begin
			disp_q <= {display_offset, 8'h0};
			xcnt_q <= 4'h0;
			ycnt_q <= 4'h0;
		end
		else
		begin
			if (da_fall)
				disp_q[3:1] <= disp_q[3:1] + 3'h1;
			if (da_fall && lo_carry)
				xcnt_q <= x_wrap ? 4'h0 : xcnt_q + 4'h1;
			if (b4_tick)
				disp_q[4] <= ~disp_q[4];
			if (y_tick)
				ycnt_q <= y_wrap ? 4'h0 : ycnt_q + 4'h1;
			if (y_tick && y_wrap)
				disp_q[15:5] <= disp_q[15:5] + 11'h1;
			// horizontal reset clears three or four low bits
			if (hr_clear)
			begin
				disp_q[3:1] <= 3'h0;
				if (!video_mode[0])
					disp_q[4] <= 1'b0;
			end
		end
	end

	// video slot denied in fast mode; refresh still served
	wire cpu_slot  = in_cpu_half & (block_select == BS_RAM);
	wire vid_slot  = ~in_cpu_half & (refresh_act | ~rate_high);
	wire slot      = cpu_slot | vid_slot;
	wire ras_zone  = slot & (sub != 3'h0);
	// page bit stands in for A15 in map 0
	wire [15:0] cpu_eff = {map_type_bit ? cpu_addr[15] : page_bit, cpu_addr[14:0]};
	wire [15:0] eff     = cpu_slot ? cpu_eff :
	                      (refresh_act ? {9'h0, refresh_q} : {disp_q, da_s});
	wire [7:0]  col_a   = mem_size_high ? eff[15:8] :
	                      (mem_size_low ? {1'b0, eff[13:7]} : {2'h0, eff[11:6]});
	wire [7:0]  mux_a   = (slot & cas_zone) ? col_a : eff[7:0];
	// bank from the address; video and refresh strobe both banks
	wire bank1     = mem_size_low ? eff[14] : eff[12];
	wire row_strobe_bank0_next = ~(ras_zone & (vid_slot | ~bank1));
	wire row_strobe_bank1_next = ~(ras_zone & (vid_slot | bank1));

	// registered memory and processor clock outputs
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			e_q        <= 1'b0;
			q_q        <= 1'b0;
			row_strobe_bank0_n_q   <= 1'b1;
			pin7_q     <= 1'b1;
			cas_n_q    <= 1'b1;
			we_n_q     <= 1'b1;
			ram_addr_q <= 8'h0;
		end
		else
		begin
			e_q        <= in_cpu_half;
			q_q        <= q_next;
			row_strobe_bank0_n_q   <= row_strobe_bank0_next;
			pin7_q     <= mem_size_high ? mux_a[7] : row_strobe_bank1_next;
			cas_n_q    <= ~(slot & cas_zone);
			we_n_q     <= ~(cpu_slot & ~cpu_rw & cas_zone);
			ram_addr_q <= mux_a;
		end
	end

	// video clock: osc/4 inside window, restart at centre
	wire outside_win = (vref_q < WIN_TA) | (vref_q > WIN_TC);
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			vref_q     <= 4'h0;
			vdiv_q     <= 2'h0;
			video_clock_pin_q     <= 1'b1;
			vsync_q    <= VS_RUN;
			stop_cnt_q <= 6'h0;
		end
		else
		begin
			vref_q <= vref_q + 4'h1;
			case (vsync_q)
				VS_RUN:
				begin
					vdiv_q     <= vdiv_q + 2'h1;
					video_clock_pin_q     <= ~vdiv_q[1];
					stop_cnt_q <= 6'h0;
					if (da_rise && outside_win)
						vsync_q <= VS_WAIT;
				end
				VS_WAIT:
				begin
					video_clock_pin_q     <= 1'b1;
					stop_cnt_q <= stop_cnt_q + 6'h1;
					vdiv_q     <= 2'h0;
					if (vref_q == WIN_TB)
						vsync_q <= VS_RUN;
				end
				default:
					vsync_q <= VS_RUN;
			endcase
		end
	end

	// port drive
	assign e_clk              = e_q;
	assign q_clk              = q_q;
	assign ram_addr           = ram_addr_q[6:0];
	assign ram_addr_bit7      = pin7_q;
	assign row_strobe_bank0_n = row_strobe_bank0_n_q;
	assign col_strobe_n       = cas_n_q;
	assign write_enable_n     = we_n_q;
	assign video_clock_pin_o  = video_clock_pin_q;
	assign video_clock_pin_oe = 1'b1;

	// checks
	a_bs_low_ram: assert property (~cpu_addr[15] |-> block_select == BS_RAM)
		else $error("low half not decoded as RAM");
	a_map1_ram: assert property (map_type_bit && !io_page |-> block_select == BS_RAM)
		else $error("map 1 not contiguous RAM");
	a_ctrl_write: assert property (ctrl_wr && !part_reset |=> ctrl_q[$past(ctrl_idx)] == $past(cpu_addr[0]))
		else $error("control bit write wrong");
	a_ctrl_hold: assert property (!ctrl_wr && !part_reset |=> $stable(ctrl_q))
		else $error("control bits changed without strobe");
	a_ext_reset: assert property ((!vpin_s)[*8] |=> ##1 ctrl_q == CTRL_RESET)
		else $error("pin low did not clear register");
	a_clocks_run: assert property (part_reset |=> phase_q != $past(phase_q))
		else $error("sequencer stalled in partial reset");
	a_stop_bound: assert property (stop_cnt_q <= VSTOP_MAX_CNT)
		else $error("video clock stop too long");
	a_win_error: assert property (vsync_q == VS_RUN && da_rise && outside_win |=> vsync_q == VS_WAIT ##1 video_clock_pin_q)
		else $error("window error missed");
	a_restart_mid: assert property (vsync_q == VS_WAIT && vref_q == WIN_TB |=> vsync_q == VS_RUN && vdiv_q == 2'h0)
		else $error("restart not at window centre");
	a_rate_select: assert property (cycle_last && !rate_high && rate_low && slow_region |=> !cycle_div8_q)
		else $error("address dependent rate wrong");
	a_fast_video: assert property (rate_high && !in_cpu_half && !refresh_act |=> row_strobe_bank0_n)
		else $error("video access in fast mode");
	a_preload: assert property (vp_pulse |=> disp_q[15:9] == $past(display_offset) && disp_q[8:1] == 8'h0)
		else $error("preload wrong");
	a_burst_load: assert property (hs_fall |=> ref_left_q == REFRESH_BURST)
		else $error("refresh burst not loaded");
	a_long_sync: assert property (long_low |-> refresh_act)
		else $error("long sync did not extend refresh");
	a_hr_clear: assert property (hr_clear && !video_mode[0] |=> disp_q[4:1] == 4'h0)
		else $error("horizontal clear wrong");
	a_page_sub: assert property (!map_type_bit |-> cpu_eff[15] == page_bit)
		else $error("page bit not substituted");
	c_ctrl_set: cover property (ctrl_wr && cpu_addr[0]);
	c_part_reset: cover property (part_reset);
	c_resync: cover property (vsync_q == VS_WAIT ##[1:20] vsync_q == VS_RUN);
	c_long_sync: cover property (long_low);

endmodule

// [tb/video_side_model.sv]
// Purpose: video generator and sync source facing the address controller
// Assumes: clk is the shared oscillator clock
// Notes:   a fetch follows each video clock rise; one slip per line forces a window error
module video_side_model
(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// video pins
	input  wire logic video_clock_pin,
	output logic      display_addr_lsb,
	output logic      horiz_sync_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int   cnt = 0;
	logic video_clock_pin_q = 1'b1;
	initial
	begin
		display_addr_lsb = 1'b0;
		horiz_sync_in = 1'b1;
	end
	// line timer with a 40 cycle low sync, data address edge on each video clock rise except at count 300
	always @(posedge clk)
	begin
		video_clock_pin_q <= video_clock_pin;
		cnt <= reset ? 0 : (cnt + 1) % 500;
		horiz_sync_in <= !(cnt >= 100 && cnt < 140);
		if (video_clock_pin && !video_clock_pin_q && cnt != 300)
			display_addr_lsb <= !display_addr_lsb;
	end
endmodule

// [tb/tb_shared_ram_address_controller.sv]
// Purpose: self-checking bench for the shared RAM address controller
// Assumes: 25 MHz clock; a pull-down on the video clock pin wins over the driver
// Notes:   control bits are observed through block select, clock rate and bank strobes
module tb_shared_ram_address_controller
	import address_controller_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        reset;
	logic [15:0] cpu_addr;
	logic        cpu_rw;
	logic [2:0]  block_select;
	logic        e_clk, q_clk, display_addr_lsb, horiz_sync_in;
	logic        video_clock_pin_o, video_clock_pin_oe, ram_addr_bit7;
	logic        row_strobe_bank0_n, col_strobe_n, write_enable_n, pull_low;
	logic [6:0]  ram_addr;
	wire logic   video_clock_pin_i;
	logic        vprev = 1'b1;
	int          fail_count, n_compared, n;
	int          run = 0;
	int          max_run = 0;
	int          toggles = 0;
	localparam logic [15:0] CORNER [16] = '{16'h0000, 16'h7fff, 16'h8000, 16'h9fff, 16'ha000, 16'hbfff,
		16'hc000, 16'hfeff, 16'hff00, 16'hff1f, 16'hff20, 16'hff5f, 16'hff60, 16'hffdf, 16'hffe0, 16'hffff};

	// pin level: pull-down wins, otherwise the design's drive
	assign video_clock_pin_i = pull_low ? 1'b0 : (video_clock_pin_oe ? video_clock_pin_o : 1'b1);

	shared_ram_address_controller shared_ram_address_controller_i (.clk(clk), .reset(reset),
		.cpu_addr(cpu_addr), .cpu_rw(cpu_rw), .block_select(block_select), .e_clk(e_clk), .q_clk(q_clk),
		.display_addr_lsb(display_addr_lsb), .horiz_sync_in(horiz_sync_in),
		.video_clock_pin_i(video_clock_pin_i), .video_clock_pin_o(video_clock_pin_o),
		.video_clock_pin_oe(video_clock_pin_oe), .ram_addr(ram_addr), .ram_addr_bit7(ram_addr_bit7),
		.row_strobe_bank0_n(row_strobe_bank0_n), .col_strobe_n(col_strobe_n),
		.write_enable_n(write_enable_n));
	video_side_model video_side_model_i (.clk(clk), .reset(reset), .video_clock_pin(video_clock_pin_i),
		.display_addr_lsb(display_addr_lsb), .horiz_sync_in(horiz_sync_in));

	// clock
	initial
	begin
		forever #20 clk = ~clk;
	end

	// video clock stop length and toggle count
	always @(negedge clk)
	begin
		run = (reset || video_clock_pin_o !== vprev) ? 0 : run + 1;
		toggles += (!reset && video_clock_pin_o !== vprev);
		max_run = (run > max_run) ? run : max_run;
		vprev = video_clock_pin_o;
	end

	task automatic tally_and_finish();
		if (fail_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk_bs(input logic [2:0] got, input logic [2:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t block select %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_num(input int got, input int exp);
		n_compared++;
		if (got != exp)
		begin
			fail_count++;
			$display("ERROR %0t value %0d expected %0d", $time, got, exp);
		end
	endtask

	// expected block select for an address and map type
	function automatic logic [2:0] bs_exp(input logic [15:0] a, input logic ty);
		if (a < 16'hff00)
			return ty ? 3'h0 : (a < 16'h8000 ? 3'h0 : a < 16'ha000 ? 3'h1 : a < 16'hc000 ? 3'h2 : 3'h3);
		if (a < 16'hff60)
			return 3'h4 + 3'(a[6:5]);
		return (a < 16'hffe0) ? 3'h7 : 3'h2;
	endfunction

	task automatic drive(input logic [15:0] a, input logic rw, input int cycles);
		cpu_addr <= a;
		cpu_rw <= rw;
		repeat (cycles) @(posedge clk);
	endtask

	// held over a whole e high window so the write is taken on each cycle of it
	task automatic set_bit(input int b, input logic v);
		drive(16'hffc0 | 16'(b * 2) | 16'(v), 1'b0, 20);
		drive(16'h1000, 1'b1, 2);
	endtask

	task automatic probe(input logic [15:0] a, input logic ty);
		cpu_addr <= a;
		cpu_rw <= 1'b1;
		@(negedge clk);
		chk_bs(block_select, bs_exp(a, ty));
		@(posedge clk);
	endtask

	task automatic sweep(input logic ty);
		foreach (CORNER[i])
			probe(CORNER[i], ty);
		repeat (40) probe(16'($urandom), ty);
	endtask

	// edges from one e clock rise to the next, bounded
	task automatic e_rise(output int cycles);
		logic p;
		cycles = 1;
		p = e_clk;
		@(posedge clk);
		while (!(e_clk === 1'b1 && p === 1'b0))
		begin
			p = e_clk;
			cycles++;
			if (cycles > 40)
			begin
				$display("ERROR %0t e clock stalled", $time);
				fail_count++;
				tally_and_finish();
			end
			@(posedge clk);
		end
	endtask

	task automatic measure(input logic [15:0] a, input int exp);
		int c;
		drive(a, 1'b1, 0);
		repeat (3) e_rise(c);
		chk_num(c, exp);
	endtask

	// which bank strobes fall during the processor half
	task automatic bank(input logic [15:0] a, input int b0, input int b1);
		int s0;
		int s1;
		int sc;
		int sw;
		int sq;
		s0 = 0;
		s1 = 0;
		sc = 0;
		sw = 0;
		sq = 0;
		drive(a, 1'b1, 16);
		repeat (40)
		begin
			@(negedge clk);
			s0 |= (e_clk === 1'b1 && row_strobe_bank0_n === 1'b0);
			s1 |= (e_clk === 1'b1 && ram_addr_bit7 === 1'b0);
			sc |= (e_clk === 1'b1 && col_strobe_n === 1'b0);
			sw |= (write_enable_n !== 1'b1);
			sq |= (e_clk === 1'b0 && q_clk === 1'b1);
		end
		@(posedge clk);
		chk_num(s0, b0);
		chk_num(s1, b1);
		chk_num(sc, 1);
		chk_num(sw, 0);
		chk_num(sq, 1);
	endtask

	// partial reset by holding the pin low, counting e clock edges meanwhile
	task automatic pull(input int cycles, output int edges);
		logic p;
		edges = 0;
		p = e_clk;
		pull_low <= 1'b1;
		repeat (cycles)
		begin
			@(posedge clk);
			edges += (e_clk !== p);
			p = e_clk;
		end
		pull_low <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// hang guard
	initial
	begin
		#3000000;
		$display("ERROR %0t run timed out", $time);
		fail_count++;
		tally_and_finish();
	end

	// main sequence
	initial
	begin
		fail_count = 0;
		n_compared = 0;
		reset = 1'b1;
		cpu_addr = 16'h1000;
		cpu_rw = 1'b1;
		pull_low = 1'b0;
		void'($urandom(50));
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		sweep(1'b0);
		drive(16'hffdf, 1'b1, 20);
		probe(16'h8000, 1'b0);
		e_rise(n);
		repeat (9) @(posedge clk);
		drive(16'hffdf, 1'b0, 3);
		probe(16'h8000, 1'b0);
		set_bit(CB_TY, 1'b1);
		sweep(1'b1);
		set_bit(CB_TY, 1'b0);
		probe(16'h8000, 1'b0);
		set_bit(CB_TY, 1'b1);
		pull(5, n);
		probe(16'h8000, 1'b1);
		pull(40, n);
		chk_num(n > 2, 1);
		probe(16'h8000, 1'b0);
		set_bit(CB_TY, 1'b1);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		probe(16'h8000, 1'b0);
		set_bit(CB_M0, 1'b1);
		bank(16'h5000, 0, 1);
		bank(16'h1000, 1, 0);
		measure(16'h9000, 16);
		set_bit(CB_R0, 1'b1);
		measure(16'h1000, 16);
		measure(16'hff10, 16);
		measure(16'h9000, 8);
		measure(16'hffff, 8);
		set_bit(CB_R1, 1'b1);
		measure(16'h1000, 8);
		chk_num(max_run <= 32, 1);
		chk_num(toggles > 100, 1);
		tally_and_finish();
	end
endmodule
